// file: src/tcs_pkg.sv
// constants and types shared by the timer clock and clear selector
package tcs_pkg;
  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam int NCH = 6;                     // timer channels
  localparam logic [7:0] OFF_CTRL0 = 8'h00;   // channel i at +4*i
  localparam logic [7:0] OFF_SYNC = 8'h18;    // sync participation
  localparam logic [7:0] OFF_MODE = 8'h1C;    // phase and buffer bits
  localparam logic [7:0] OFF_STAT = 8'h20;    // live outputs, read only
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [5:0] SYNC_RST = 6'h00;
  localparam logic [5:0] MODE_RST = 6'h00;
  // ------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------
  localparam int CS_HI = 7;                   // clear select
  localparam int CS_LO = 5;
  localparam int EG_HI = 4;                   // edge select
  localparam int EG_LO = 3;
  localparam int CK_HI = 2;                   // clock select
  localparam int CK_LO = 0;
  localparam int MODE_PH = 0;                 // phase counting [5:0]
  localparam int MODE_BC = 8;                 // buffer on reg c
  localparam int MODE_BD = 16;                // buffer on reg d
  localparam int STAT_CLR = 8;                // clear outputs
  // channel masks: which channels own the feature
  localparam logic [5:0] PH_MASK = 6'h36;     // channels 1,2,4,5
  localparam logic [5:0] CD_MASK = 6'h09;     // channels 0,3
  // ------------------------------------------------------------
  // clear select codes
  // ------------------------------------------------------------
  localparam logic [2:0] CLR_A = 3'h1;
  localparam logic [2:0] CLR_B = 3'h2;
  localparam logic [2:0] CLR_SYN = 3'h3;
  localparam logic [2:0] CLR_C = 3'h5;
  localparam logic [2:0] CLR_D = 3'h6;
  localparam logic [2:0] CLR_SYN2 = 3'h7;
  // ------------------------------------------------------------
  // count sources and prescaler
  // ------------------------------------------------------------
  localparam int PRE_W = 12;                  // reaches divide by 4096
  typedef enum logic [3:0] {
    SRC_PHI1, SRC_D4, SRC_D16, SRC_D64, SRC_D256, SRC_D1024,
    SRC_D4096, SRC_PIN_A, SRC_PIN_B, SRC_PIN_C, SRC_PIN_D, SRC_OVF
  } tcs_src_t;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// file: src/tcs_top.sv
// count source and counter clear selection for six timer channels
//
// Summary of operation
// - clear code 001 clears on register a event
// - code 010 clears on b; 000 none
// - code 011 follows other synchronous channel clears
// - sync participation only while sync bit set
// - buffered c or d never clears counter
// - clear select top bit zero on 1,2,4,5
// - codes 000-011 give divide 1,4,16,64
// - code 100 counts external pin a
// - channel 0: 101-111 pins b, c, d
// - channel 1: pin b, /256, channel 2 overflow
// - channel 2: pin b, pin c, /1024
// - channel 3: /1024, /256, /4096
// - channel 4: pin c, /1024, channel 5 overflow
// - channel 5: pin c, /256, pin d
// - phase counting mode ignores clock select
// - edge 00 rise, 01 fall, 1x both
// - edge ignored for /1 and overflow
`timescale 1ns/1ps
module tcs_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_clk_pin_a,
  input wire logic ext_clk_pin_b,
  input wire logic ext_clk_pin_c,
  input wire logic ext_clk_pin_d,
  input wire logic ch2_ovf_unf,
  input wire logic ch5_ovf_unf,
  input wire logic [5:0] gra_event,
  input wire logic [5:0] grb_event,
  input wire logic [5:0] grc_event,
  input wire logic [5:0] grd_event,
  output logic [5:0] count_en,
  output logic [5:0] counter_clear
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] ctrl_q [tcs_pkg::NCH];  // per channel control
  logic [7:0] ctrl_d [tcs_pkg::NCH];
  logic [5:0] sync_q, sync_d;         // sync participation
  logic [5:0] phase_q, phase_d;       // phase counting mode
  logic [5:0] bufc_q, bufc_d;         // reg c used as buffer
  logic [5:0] bufd_q, bufd_d;         // reg d used as buffer
  logic [tcs_pkg::PRE_W-1:0] pre_q, pre_d;  // shared prescaler
  logic [9:0] lvl;                    // tap and pin levels now
  logic [9:0] lvl_q;                  // the same one cycle back
  logic [5:0] en_d, en_q;
  logic [5:0] clr_d, clr_q;
  logic [5:0] own_clr;                // clears from local events
  // bus side
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic wstrb0_q, wstrb0_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;

  // ------------------------------------------------------------
  // source lookup per channel and code
  // ------------------------------------------------------------
  // codes 0..4 are common; the upper three differ per channel
  function automatic tcs_pkg::tcs_src_t src_of(input int ch,
                                               input logic [2:0] c);
    tcs_pkg::tcs_src_t s;
    s = tcs_pkg::SRC_PHI1;
    unique case (c)
      3'h0: s = tcs_pkg::SRC_PHI1;
      3'h1: s = tcs_pkg::SRC_D4;
      3'h2: s = tcs_pkg::SRC_D16;
      3'h3: s = tcs_pkg::SRC_D64;
      3'h4: s = tcs_pkg::SRC_PIN_A;
      3'h5: begin
        if (ch == 0 || ch == 1 || ch == 2) s = tcs_pkg::SRC_PIN_B;
        else if (ch == 3) s = tcs_pkg::SRC_D1024;
        else s = tcs_pkg::SRC_PIN_C;
      end
      3'h6: begin
        if (ch == 0 || ch == 2) s = tcs_pkg::SRC_PIN_C;
        else if (ch == 4) s = tcs_pkg::SRC_D1024;
        else s = tcs_pkg::SRC_D256;
      end
      default: begin
        if (ch == 0 || ch == 5) s = tcs_pkg::SRC_PIN_D;
        else if (ch == 2) s = tcs_pkg::SRC_D1024;
        else if (ch == 3) s = tcs_pkg::SRC_D4096;
        else s = tcs_pkg::SRC_OVF;
      end
    endcase
    return s;
  endfunction

  // ------------------------------------------------------------
  // prescaler and level history
  // ------------------------------------------------------------
  // one free-running counter; its bits are square waves whose
  // edges become count enables, so no derived clocks exist
  always_comb begin
    pre_d = pre_q + 1'b1;
    lvl = {ext_clk_pin_d, ext_clk_pin_c, ext_clk_pin_b,
           ext_clk_pin_a, pre_q[11], pre_q[9], pre_q[7],
           pre_q[5], pre_q[3], pre_q[1]};
  end

  // ------------------------------------------------------------
  // per channel count enable and clear
  // ------------------------------------------------------------
  for (genvar i = 0; i < tcs_pkg::NCH; i++) begin : g_ch
    logic [2:0] cs;
    logic [1:0] eg;
    tcs_pkg::tcs_src_t src;
    logic lv, pv, ovf, ce, oc;
    always_comb begin
      cs = ctrl_q[i][tcs_pkg::CS_HI:tcs_pkg::CS_LO];
      eg = ctrl_q[i][tcs_pkg::EG_HI:tcs_pkg::EG_LO];
      src = src_of(i, ctrl_q[i][tcs_pkg::CK_HI:tcs_pkg::CK_LO]);
      ovf = (i == 1) ? ch2_ovf_unf : ch5_ovf_unf;
      lv = 1'b0;
      pv = 1'b0;
      if (src != tcs_pkg::SRC_PHI1 && src != tcs_pkg::SRC_OVF) begin
        lv = lvl[4'(src) - 4'h1];
        pv = lvl_q[4'(src) - 4'h1];
      end
      if (src == tcs_pkg::SRC_PHI1) begin
        ce = 1'b1;
      end else if (src == tcs_pkg::SRC_OVF) begin
        ce = ovf;
      end else if (eg[1]) begin
        ce = lv ^ pv;
      end else if (eg[0]) begin
        ce = pv & ~lv;
      end else begin
        ce = lv & ~pv;
      end
      // phase counting channels take counts from the quadrature
      // logic outside, so the selected source is dropped here
      en_d[i] = ce & ~phase_q[i];
      // local clear sources; a buffered c or d raises no event
      unique case (cs)
        tcs_pkg::CLR_A: oc = gra_event[i];
        tcs_pkg::CLR_B: oc = grb_event[i];
        tcs_pkg::CLR_C: oc = grc_event[i] & ~bufc_q[i];
        tcs_pkg::CLR_D: oc = grd_event[i] & ~bufd_q[i];
        default: oc = 1'b0;
      endcase
    end
    assign own_clr[i] = oc;
  end

  // synchronous clearing: only participants follow, and only
  // another participant's local clear counts, so no loop forms
  always_comb begin
    for (int i = 0; i < tcs_pkg::NCH; i++) begin
      logic [2:0] c;
      logic [5:0] others;
      c = ctrl_q[i][tcs_pkg::CS_HI:tcs_pkg::CS_LO];
      others = own_clr & sync_q & ~(6'h01 << i);
      clr_d[i] = own_clr[i];
      if ((c == tcs_pkg::CLR_SYN || c == tcs_pkg::CLR_SYN2)
          && sync_q[i]) begin
        clr_d[i] = |others;
      end
    end
  end

  // ------------------------------------------------------------
  // axi4-lite write path
  // ------------------------------------------------------------
  // address and data are caught separately in either order; the
  // write lands once both are held and no response is pending
  always_comb begin
    logic [7:0] a;
    logic [31:0] wd;
    logic go;
    a = (s_axi_awvalid & awready_q) ? s_axi_awaddr : awaddr_q;
    wd = (s_axi_wvalid & wready_q) ? s_axi_wdata : wdata_q;
    aw_hold_d = aw_hold_q | (s_axi_awvalid & awready_q);
    w_hold_d = w_hold_q | (s_axi_wvalid & wready_q);
    go = aw_hold_d & w_hold_d & ~bvalid_q;
    awaddr_d = a;
    wdata_d = wd;
    wstrb0_d = (s_axi_wvalid & wready_q) ? s_axi_wstrb[0] : wstrb0_q;
    bvalid_d = bvalid_q & ~s_axi_bready;
    bresp_d = bresp_q;
    ctrl_d = ctrl_q;
    sync_d = sync_q;
    phase_d = phase_q;
    bufc_d = bufc_q;
    bufd_d = bufd_q;
    if (go) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = tcs_pkg::RESP_OKAY;
      if (a[1:0] == 2'h0 && a < tcs_pkg::OFF_SYNC) begin
        // only byte lane 0 holds bits; other lanes are dropped
        if (wstrb0_d) begin
          ctrl_d[a[4:2]] = wd[7:0];
          if (!tcs_pkg::CD_MASK[a[4:2]]) begin
            ctrl_d[a[4:2]][tcs_pkg::CS_HI] = 1'b0;
          end
        end
      end else if (a == tcs_pkg::OFF_SYNC) begin
        if (wstrb0_d) sync_d = wd[5:0];
      end else if (a == tcs_pkg::OFF_MODE) begin
        // lanes 0 to 2 each carry one group of mode bits; lane 3 is unused
        // the held lane 0 strobe, since data may have come earlier
        if (wstrb0_d) begin
          phase_d = wd[tcs_pkg::MODE_PH +: 6] & tcs_pkg::PH_MASK;
        end
        bufc_d = wd[tcs_pkg::MODE_BC +: 6] & tcs_pkg::CD_MASK;
        bufd_d = wd[tcs_pkg::MODE_BD +: 6] & tcs_pkg::CD_MASK;
      end else if (a != tcs_pkg::OFF_STAT) begin
        bresp_d = tcs_pkg::RESP_DECERR;          // unmapped
      end
    end
    awready_d = ~aw_hold_d & ~bvalid_d;
    wready_d = ~w_hold_d & ~bvalid_d;
  end

  // ------------------------------------------------------------
  // axi4-lite read path
  // ------------------------------------------------------------
  // one read at a time; data is latched at the address handshake
  always_comb begin
    logic [7:0] a;
    a = s_axi_araddr;
    rvalid_d = rvalid_q & ~s_axi_rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid & arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = tcs_pkg::RESP_OKAY;
      rdata_d = 32'h0000_0000;
      if (a[1:0] == 2'h0 && a < tcs_pkg::OFF_SYNC) begin
        rdata_d[7:0] = ctrl_q[a[4:2]];
      end else if (a == tcs_pkg::OFF_SYNC) begin
        rdata_d[5:0] = sync_q;
      end else if (a == tcs_pkg::OFF_MODE) begin
        rdata_d[tcs_pkg::MODE_PH +: 6] = phase_q;
        rdata_d[tcs_pkg::MODE_BC +: 6] = bufc_q;
        rdata_d[tcs_pkg::MODE_BD +: 6] = bufd_q;
      end else if (a == tcs_pkg::OFF_STAT) begin
        rdata_d[5:0] = en_q;
        rdata_d[tcs_pkg::STAT_CLR +: 6] = clr_q;
      end else begin
        rresp_d = tcs_pkg::RESP_DECERR;
      end
    end
    arready_d = ~rvalid_d;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < tcs_pkg::NCH; i++) begin
        ctrl_q[i] <= tcs_pkg::CTRL_RST;
      end
      sync_q <= tcs_pkg::SYNC_RST;
      phase_q <= tcs_pkg::MODE_RST;
      bufc_q <= tcs_pkg::MODE_RST;
      bufd_q <= tcs_pkg::MODE_RST;
      pre_q <= '0;
      lvl_q <= 10'h000;
      en_q <= 6'h00;
      clr_q <= 6'h00;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
    end else begin
      ctrl_q <= ctrl_d;
      sync_q <= sync_d;
      phase_q <= phase_d;
      bufc_q <= bufc_d;
      bufd_q <= bufd_d;
      pre_q <= pre_d;
      lvl_q <= lvl;
      en_q <= en_d;
      clr_q <= clr_d;
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb0_q <= wstrb0_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign count_en = en_q;
  assign counter_clear = clr_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_CLR_A: assert property (
    (ctrl_q[1][7:5] == 3'h1 && gra_event[1]) |=> counter_clear[1])
    else $error("register a event did not clear channel 1");
  AST_CLR_OFF: assert property (
    (ctrl_q[2][7:5] == 3'h0) |=> !counter_clear[2])
    else $error("clear seen with clearing disabled");
  AST_SYNC_FOLLOW: assert property (
    (ctrl_q[1][7:5] == 3'h3 && sync_q[1] && sync_q[0]
     && ctrl_q[0][7:5] == 3'h1 && gra_event[0])
    |=> counter_clear[0] && counter_clear[1])
    else $error("sync partner clear not followed");
  AST_SYNC_OFF: assert property (
    (ctrl_q[1][7:5] == 3'h3 && !sync_q[1]) |=> !counter_clear[1])
    else $error("non participant cleared by sync");
  AST_BUF_C: assert property (
    (ctrl_q[0][7:5] == 3'h5 && bufc_q[0]) |=> !counter_clear[0])
    else $error("buffered register c cleared counter");
  AST_TOP_ZERO: assert property (
    !ctrl_q[1][7] && !ctrl_q[2][7] && !ctrl_q[4][7] && !ctrl_q[5][7])
    else $error("reserved clear select bit set");
  AST_DIV4_GAP: assert property (
    (count_en[3] && ctrl_q[3][4:0] == 5'h01
     && $past(ctrl_q[3][4:0]) == 5'h01)
    |=> (!count_en[3] || ctrl_q[3][4:0] != 5'h01) [*3])
    else $error("divide by 4 enable too frequent");
  AST_PIN_A: assert property (
    (ctrl_q[0][4:0] == 5'h04 && ext_clk_pin_a && !lvl_q[6])
    |=> count_en[0])
    else $error("pin a rising edge not counted");
  AST_PHASE: assert property (
    phase_q[2] |=> !count_en[2])
    else $error("phase counting channel counted from select");
  AST_PHI1: assert property (
    (ctrl_q[5][2:0] == 3'h0 && !phase_q[5]) |=> count_en[5])
    else $error("undivided clock not counted every cycle");

  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
  COV_SYNC: cover property (counter_clear[0] && counter_clear[1]);
  COV_OVF: cover property (ctrl_q[1][2:0] == 3'h7 && count_en[1]);
endmodule

// file: testbench/tcs_far_model.sv
// far-side model: external clock pins and sibling channel overflows
`timescale 1ns/1ps
module tcs_far_model #(
  parameter int HALF_A = 3,
  parameter int HALF_B = 5,
  parameter int HALF_C = 7,
  parameter int HALF_D = 9,
  parameter int OVF2_PER = 11,
  parameter int OVF5_PER = 13
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic [3:0] pins,
  output logic ch2_ovf,
  output logic ch5_ovf
);
  // ------------------------------------------------------------
  // free-running pin levels and overflow pulses
  // ------------------------------------------------------------
  // distinct half periods so a wrong pin choice shows as a wrong period
  localparam int HALF [4] = '{HALF_A, HALF_B, HALF_C, HALF_D};
  int pin_cnt_q [4];  // cycles since last pin toggle
  int ovf2_cnt_q;     // cycles since channel 2 wrapped
  int ovf5_cnt_q;     // cycles since channel 5 wrapped
  // pins change right after an edge, like a synchronised input
  always @(posedge aclk) begin
    if (!aresetn) begin
      pins <= 4'h0;
      ch2_ovf <= 1'b0;
      ch5_ovf <= 1'b0;
      ovf2_cnt_q <= 0;
      ovf5_cnt_q <= 0;
      for (int i = 0; i < 4; i++) begin
        pin_cnt_q[i] <= 0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (pin_cnt_q[i] >= HALF[i] - 1) begin
          pin_cnt_q[i] <= 0;
          pins[i] <= ~pins[i];
        end else begin
          pin_cnt_q[i] <= pin_cnt_q[i] + 1;
        end
      end
      // one-cycle wrap pulses from the sibling counters
      ovf2_cnt_q <= (ovf2_cnt_q >= OVF2_PER - 1) ? 0 : ovf2_cnt_q + 1;
      ovf5_cnt_q <= (ovf5_cnt_q >= OVF5_PER - 1) ? 0 : ovf5_cnt_q + 1;
      ch2_ovf <= (ovf2_cnt_q == OVF2_PER - 1);
      ch5_ovf <= (ovf5_cnt_q == OVF5_PER - 1);
    end
  end
endmodule

// file: testbench/testbench.sv
// self-checking bench for the timer clock and clear selector
`timescale 1ns/1ps
module testbench;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, pins;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, ch2_ovf, ch5_ovf;
  logic [5:0] gra_event, grb_event, grc_event, grd_event;
  logic [5:0] count_en, counter_clear;
  int err_count = 0;  // mismatches seen
  int cmp_count = 0;  // comparisons made
  tcs_top i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ext_clk_pin_a(pins[0]),
    .ext_clk_pin_b(pins[1]), .ext_clk_pin_c(pins[2]),
    .ext_clk_pin_d(pins[3]), .ch2_ovf_unf(ch2_ovf),
    .ch5_ovf_unf(ch5_ovf), .gra_event(gra_event), .grb_event(grb_event),
    .grc_event(grc_event), .grd_event(grd_event), .count_en(count_en),
    .counter_clear(counter_clear));
  tcs_far_model i_far (.aclk(aclk), .aresetn(aresetn), .pins(pins),
    .ch2_ovf(ch2_ovf), .ch5_ovf(ch5_ovf));
  // ------------------------------------------------------------
  // reporting
  // ------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // a wait that ran out ends the run at once
  task automatic timed_out(input string what);
    err_count++;
    $display("[FAIL] %s expected answer seen timeout", what);
    final_report();
  endtask
  // ------------------------------------------------------------
  // bus master tasks
  // ------------------------------------------------------------
  // bready is raised with the request and held until bvalid is sampled
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    if (n >= 50) timed_out("bvalid");
    check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
      input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    if (n >= 50) timed_out("rvalid");
    check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  task automatic wr_ctrl(input int ch, input logic [7:0] v);
    axi_wr(tcs_pkg::OFF_CTRL0 + 8'(4 * ch), {24'h0, v}, tcs_pkg::RESP_OKAY);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // reset values, reserved clear bit, unmapped place
  task automatic regs_case();
    logic [31:0] d;
    for (int ch = 0; ch < 6; ch++) begin
      axi_rd(tcs_pkg::OFF_CTRL0 + 8'(4 * ch), d, tcs_pkg::RESP_OKAY);
      check("ctrl reset", 32'h0, d);
    end
    axi_rd(tcs_pkg::OFF_SYNC, d, tcs_pkg::RESP_OKAY);
    check("sync reset", 32'h0, d);
    wr_ctrl(1, 8'hFF);
    axi_rd(8'h04, d, tcs_pkg::RESP_OKAY);
    check("ctrl1 top bit", 32'h7F, d);
    wr_ctrl(3, 8'hFF);
    axi_rd(8'h0C, d, tcs_pkg::RESP_OKAY);
    check("ctrl3 top bit", 32'hFF, d);
    axi_wr(8'h24, 32'hFFFFFFFF, tcs_pkg::RESP_DECERR);
    axi_rd(8'h24, d, tcs_pkg::RESP_DECERR);
    check("unmapped read", 32'h0, d);
  endtask
  // period between the 2nd and 3rd count enable after a source change
  task automatic meas(input int ch, input logic [7:0] ctrl, input int per);
    int n;
    int gap;
    int seen;
    wr_ctrl(ch, ctrl);
    seen = 0;
    gap = 0;
    n = 0;
    // the slowest tap needs up to three periods of 4096 cycles
    while (seen < 3 && n < 13000) begin
      @(posedge aclk);
      #1;
      n++;
      gap++;
      if (count_en[ch] === 1'b1) begin
        seen++;
        if (seen == 2) gap = 0;
      end
    end
    if (seen < 3) timed_out("count_en");
    check("count period", per, gap);
  endtask
  // one event cycle, then the clear outputs one cycle later
  task automatic clr_case(input logic [5:0] a, input logic [5:0] b,
      input logic [5:0] c, input logic [5:0] d, input logic [5:0] exp);
    @(posedge aclk);
    gra_event <= a;
    grb_event <= b;
    grc_event <= c;
    grd_event <= d;
    @(posedge aclk);
    gra_event <= 6'h00;
    grb_event <= 6'h00;
    grc_event <= 6'h00;
    grd_event <= 6'h00;
    #1;
    check("counter_clear", {26'h0, exp}, {26'h0, counter_clear});
  endtask
  // phase mode holds the count enable low whatever the clock select
  task automatic phase_case();
    logic [31:0] d;
    int hits;
    axi_wr(tcs_pkg::OFF_MODE, 32'h003F3F3F, tcs_pkg::RESP_OKAY);
    axi_rd(tcs_pkg::OFF_MODE, d, tcs_pkg::RESP_OKAY);
    check("mode bits", 32'h00090936, d);
    wr_ctrl(1, 8'h00);
    hits = 0;
    repeat (40) begin
      @(posedge aclk);
      #1;
      if (count_en[1] !== 1'b0) hits++;
    end
    check("phase count_en", 32'h0, hits);
    axi_wr(tcs_pkg::OFF_MODE, 32'h0, tcs_pkg::RESP_OKAY);
  endtask
  // ------------------------------------------------------------
  // clock and main sequence
  // ------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    {gra_event, grb_event, grc_event, grd_event} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    regs_case();
    meas(3, 8'h00, 1);
    meas(3, 8'h01, 4);
    meas(3, 8'h02, 16);
    meas(3, 8'h03, 64);
    meas(3, 8'h05, 1024);
    meas(3, 8'h06, 256);
    meas(3, 8'h07, 4096);
    meas(1, 8'h06, 256);
    meas(2, 8'h07, 1024);
    meas(4, 8'h06, 1024);
    meas(5, 8'h06, 256);
    meas(3, 8'h11, 2);
    meas(3, 8'h09, 4);
    meas(3, 8'h10, 1);
    meas(0, 8'h04, 6);
    meas(2, 8'h04, 6);
    meas(0, 8'h05, 10);
    meas(0, 8'h06, 14);
    meas(0, 8'h07, 18);
    meas(1, 8'h05, 10);
    meas(1, 8'h07, 11);
    meas(2, 8'h05, 10);
    meas(2, 8'h06, 14);
    meas(4, 8'h05, 14);
    meas(4, 8'h07, 13);
    meas(5, 8'h05, 14);
    meas(5, 8'h07, 18);
    meas(0, 8'h0C, 6);
    meas(0, 8'h14, 3);
    meas(1, 8'h1F, 11);
    phase_case();
    wr_ctrl(0, 8'h00);
    wr_ctrl(1, 8'h20);
    clr_case(6'h02, 6'h00, 6'h00, 6'h00, 6'h02);
    clr_case(6'h00, 6'h02, 6'h00, 6'h00, 6'h00);
    wr_ctrl(1, 8'h40);
    clr_case(6'h00, 6'h02, 6'h00, 6'h00, 6'h02);
    clr_case(6'h02, 6'h00, 6'h00, 6'h00, 6'h00);
    wr_ctrl(1, 8'h00);
    clr_case(6'h3F, 6'h3F, 6'h00, 6'h00, 6'h00);
    wr_ctrl(0, 8'h20);
    wr_ctrl(1, 8'h60);
    axi_wr(tcs_pkg::OFF_SYNC, 32'h03, tcs_pkg::RESP_OKAY);
    clr_case(6'h01, 6'h00, 6'h00, 6'h00, 6'h03);
    axi_wr(tcs_pkg::OFF_SYNC, 32'h01, tcs_pkg::RESP_OKAY);
    clr_case(6'h01, 6'h00, 6'h00, 6'h00, 6'h01);
    wr_ctrl(0, 8'hE0);
    wr_ctrl(1, 8'h20);
    axi_wr(tcs_pkg::OFF_SYNC, 32'h03, tcs_pkg::RESP_OKAY);
    clr_case(6'h02, 6'h00, 6'h00, 6'h00, 6'h03);
    wr_ctrl(0, 8'hA0);
    clr_case(6'h00, 6'h00, 6'h01, 6'h00, 6'h01);
    axi_wr(tcs_pkg::OFF_MODE, 32'h00000100, tcs_pkg::RESP_OKAY);
    clr_case(6'h00, 6'h00, 6'h01, 6'h00, 6'h00);
    wr_ctrl(0, 8'hC0);
    clr_case(6'h00, 6'h00, 6'h00, 6'h01, 6'h01);
    axi_wr(tcs_pkg::OFF_MODE, 32'h00010000, tcs_pkg::RESP_OKAY);
    clr_case(6'h00, 6'h00, 6'h00, 6'h01, 6'h00);
    final_report();
  end
endmodule
